// *** ddauc_addr_step.sv ***
// Purpose : next destination address and repeat-area wrap detection
// Assumes : purely combinational, evaluated for the current transfer
// Notes   : prohibited area codes behave as no repeat area
`timescale 1ns/10ps
`default_nettype none
module ddauc_addr_step (
    input  wire logic [ddauc_pkg::ADDR_W-1:0] addr,
    input  wire logic [1:0]                   upd_mode,
    input  wire logic                         word,
    input  wire logic [ddauc_pkg::CODE_W-1:0] area_code,
    input  wire logic                         ignore,
    output logic      [ddauc_pkg::ADDR_W-1:0] next_addr,
    output logic      [ddauc_pkg::ADDR_W-1:0] area_mask,
    output logic                              wrap
);
    import ddauc_pkg::*;

    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] low;
    logic [ADDR_W-1:0] upper;

    // mask of the lower n bits; code zero means no area
    always_comb begin
        area_mask = '0;
        if (area_code != CODE_NONE && area_code <= CODE_MAX) begin
            area_mask = ~({ADDR_W{1'b1}} << area_code);
        end
    end

    // step by access size, wrap only the lower bits; with a repeat area set the upper bits never move
    always_comb begin
        step      = word ? STEP_WORD : STEP_BYTE;
        low       = addr & area_mask;
        upper     = addr & ~area_mask;
        next_addr = addr;
        wrap      = 1'b0;
        if (!ignore) begin
            unique case (upd_mode)
                UPD_INC: begin
                    if (|area_mask && (low + step) > area_mask) begin
                        wrap      = 1'b1;
                        next_addr = upper;
                    end else begin
                        next_addr = addr + step;
                    end
                end
                UPD_DEC: begin
                    if (|area_mask && low < step) begin
                        wrap      = 1'b1;
                        next_addr = upper | area_mask;
                    end else begin
                        next_addr = addr - step;
                    end
                end
                UPD_FIXED0,
                UPD_FIXED1: next_addr = addr;
            endcase
        end
    end
endmodule // ddauc_addr_step
`default_nettype wire

// *** ddauc_pkg.sv ***
// Purpose : constants and types for the destination address update control
// Assumes : one 250 MHz clock, Avalon-MM register slave with byte addresses
// Notes   : every offset and field position is named here, plus the control and address reset values
`default_nettype none
package ddauc_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int BUS_AW = 5;
    localparam int CODE_W = 5;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [BUS_AW-1:0] OFF_CTRL  = 5'h00;
    localparam logic [BUS_AW-1:0] OFF_DADDR = 5'h04;
    localparam logic [BUS_AW-1:0] OFF_MODE  = 5'h08;
    localparam logic [BUS_AW-1:0] OFF_STAT  = 5'h0C;
    localparam logic [BUS_AW-1:0] OFF_MASK  = 5'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int UPD_HI_BIT = 7;
    localparam int UPD_LO_BIT = 6;
    localparam int RIE_BIT    = 5;
    localparam int AREA_MSB   = 4;
    localparam int ACT_BIT    = 0;
    localparam int BLK_BIT    = 1;
    localparam int ACKPIN_BIT = 2;
    localparam int FLAG_BIT   = 0;
    localparam int IEN_BIT    = 0;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0]        CTRL_RST  = 8'h00;
    localparam logic [ADDR_W-1:0] DADDR_RST = 24'h000000;
    localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;
    localparam logic [CODE_W-1:0] CODE_MAX  = 5'h17;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;

    typedef enum logic [1:0] {
        UPD_FIXED0 = 2'b00,
        UPD_FIXED1 = 2'b01,
        UPD_INC    = 2'b10,
        UPD_DEC    = 2'b11
    } ddauc_upd_t;

endpackage
`default_nettype wire

// *** ddauc_top.sv ***
// Purpose : destination address update control of one dma channel
// Assumes : transfer engine pulses xfer_done once per completed transfer
// Notes   : registers on Avalon-MM, one-cycle waitrequest answer
//
// Contract
// - mode bits 7:6, enable bit 5, reset zero
// - upper mode bit zero fixed; increment +1/+2
// - decrement by one byte, two word
// - external acknowledged destination ignores update mode
// - enabled overflow sets flag, stops transfer
// - flag with channel enable requests interrupt
// - block mode raises only at block end
// - setting active again resumes stopped channel
// - enable ignored without designated repeat area
// - enable zero: overflow neither flags nor stops
// - overflow wraps lower bits to start/last
// - five-bit area code, zero means none
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module ddauc_top (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic [ddauc_pkg::BUS_AW-1:0] avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [ddauc_pkg::DATA_W-1:0] avs_writedata,
    output logic      [ddauc_pkg::DATA_W-1:0] avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic                         xfer_done,
    input  wire logic                         xfer_word,
    input  wire logic                         block_end,
    output logic      [ddauc_pkg::ADDR_W-1:0] dest_addr,
    output logic                              xfer_active,
    output logic                              irq
);
    import ddauc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]        ctrl_r;
    logic [ADDR_W-1:0] dest_addr_reg_r;
    logic              xfer_active_r;
    logic              block_mode_r;
    logic              ackpin_single_r;
    logic              irq_flag_r;
    logic              channel_irq_en_r;
    logic              wrap_pend_r;
    logic              irq_r;
    logic              wait_r;
    logic [DATA_W-1:0] rdata_r;

    logic [ADDR_W-1:0] next_addr;
    logic [ADDR_W-1:0] area_mask;
    logic              wrap;
    logic              wr_hit;
    logic              rd_req;
    logic              xfer_ev;
    logic              overflow_now;
    logic              fire;
    logic              terminate;
    logic              area_valid;
    logic [1:0]        upd_mode;
    logic [DATA_W-1:0] rdata_nxt;

    assign upd_mode = {ctrl_r[UPD_HI_BIT], ctrl_r[UPD_LO_BIT]};

    // ----------------------------------------------------------------
    // address arithmetic
    // ----------------------------------------------------------------
    ddauc_addr_step u_step (
        .addr      (dest_addr_reg_r),
        .upd_mode  (upd_mode),
        .word      (xfer_word),
        .area_code (ctrl_r[AREA_MSB:0]),
        .ignore    (ackpin_single_r),
        .next_addr (next_addr),
        .area_mask (area_mask),
        .wrap      (wrap)
    );

    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------
    // transfers while stopped are ignored so a stopped channel keeps its state
    assign xfer_ev      = xfer_done && xfer_active_r;
    assign overflow_now = xfer_ev && wrap;
    assign area_valid   = |area_mask;
    // in block mode an overflow is remembered until the block finishes
    assign fire = block_mode_r ? (xfer_ev && block_end && (wrap_pend_r || wrap))
                               : overflow_now;
    assign terminate = fire && ctrl_r[RIE_BIT] && area_valid;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // every access waits exactly one cycle; the write lands on the accepting edge
    assign wr_hit = avs_write && !wait_r;
    assign rd_req = avs_read && wait_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 1'b1;
        end else if ((avs_read || avs_write) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        rdata_nxt = '0;
        unique case (avs_address)
            OFF_CTRL:  rdata_nxt[7:0]          = ctrl_r;
            OFF_DADDR: rdata_nxt[ADDR_W-1:0]   = dest_addr_reg_r;
            OFF_MODE: begin
                rdata_nxt[ACT_BIT]    = xfer_active_r;
                rdata_nxt[BLK_BIT]    = block_mode_r;
                rdata_nxt[ACKPIN_BIT] = ackpin_single_r;
            end
            OFF_STAT:  rdata_nxt[FLAG_BIT]     = irq_flag_r;
            OFF_MASK:  rdata_nxt[IEN_BIT]      = channel_irq_en_r;
            default:   rdata_nxt               = '0;
        endcase
    end

    // read data is captured so it stands at the edge waitrequest is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else if (rd_req) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // address control byte, cleared at reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_hit && avs_address == OFF_CTRL) begin
            ctrl_r <= avs_writedata[7:0];
        end
    end

    // mode bits; hardware termination beats a software write in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xfer_active_r   <= 1'b0;
            block_mode_r    <= 1'b0;
            ackpin_single_r <= 1'b0;
        end else begin
            if (terminate) begin
                xfer_active_r <= 1'b0;
            end else if (wr_hit && avs_address == OFF_MODE) begin
                xfer_active_r <= avs_writedata[ACT_BIT];
            end
            if (wr_hit && avs_address == OFF_MODE) begin
                block_mode_r    <= avs_writedata[BLK_BIT];
                ackpin_single_r <= avs_writedata[ACKPIN_BIT];
            end
        end
    end

    // mask register holds the channel interrupt enable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            channel_irq_en_r <= 1'b0;
        end else if (wr_hit && avs_address == OFF_MASK) begin
            channel_irq_en_r <= avs_writedata[IEN_BIT];
        end
    end

    // sticky flag, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_r <= 1'b0;
        end else if (terminate) begin
            irq_flag_r <= 1'b1;
        end else if (wr_hit && avs_address == OFF_STAT && avs_writedata[FLAG_BIT]) begin
            irq_flag_r <= 1'b0;
        end
    end

    // level interrupt, registered so the output comes from a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_flag_r && channel_irq_en_r;
        end
    end

    // ----------------------------------------------------------------
    // address and block bookkeeping
    // ----------------------------------------------------------------
    // a transfer update beats a software write to the address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dest_addr_reg_r <= DADDR_RST;
        end else if (xfer_ev) begin
            dest_addr_reg_r <= next_addr;
        end else if (wr_hit && avs_address == OFF_DADDR) begin
            dest_addr_reg_r <= avs_writedata[ADDR_W-1:0];
        end
    end

    // overflow seen inside a block waits for the block end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrap_pend_r <= 1'b0;
        end else if (!block_mode_r || (xfer_ev && block_end)) begin
            wrap_pend_r <= 1'b0;
        end else if (overflow_now) begin
            wrap_pend_r <= 1'b1;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign dest_addr       = dest_addr_reg_r;
    assign xfer_active     = xfer_active_r;
    assign irq             = irq_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_mode_write_go;
        wr_hit && avs_address == OFF_MODE && avs_writedata[ACT_BIT];
    endsequence

    sequence s_stopped;
        !xfer_active_r && irq_flag_r;
    endsequence

    a_fixed_hold: assert property (xfer_ev && !upd_mode[1] |=> $stable(dest_addr))
        else $error("fixed mode moved the address");
    a_inc_step: assert property (xfer_ev && upd_mode == UPD_INC && !ackpin_single_r && !wrap
        |=> dest_addr == $past(dest_addr) + (($past(xfer_word)) ? STEP_WORD : STEP_BYTE))
        else $error("increment step wrong");
    a_dec_step: assert property (xfer_ev && upd_mode == UPD_DEC && !ackpin_single_r && !wrap
        |=> dest_addr == $past(dest_addr) - (($past(xfer_word)) ? STEP_WORD : STEP_BYTE))
        else $error("decrement step wrong");
    a_ackpin_ignore: assert property (xfer_ev && ackpin_single_r |=> $stable(dest_addr))
        else $error("address moved for acknowledged destination");
    a_term_effect: assert property (terminate |=> irq_flag_r && !xfer_active_r)
        else $error("termination did not flag and stop");
    a_irq_request: assert property (irq_flag_r && channel_irq_en_r |=> irq)
        else $error("interrupt not requested");
    a_block_wait: assert property (block_mode_r && xfer_ev && !block_end |=> !$rose(irq_flag_r))
        else $error("flag raised inside a block");
    a_resume_go: assert property (s_stopped ##0 s_mode_write_go ##0 !terminate
        |=> xfer_active_r && $stable(dest_addr))
        else $error("channel did not resume");
    a_no_area: assert property (xfer_ev && ctrl_r[AREA_MSB:0] == CODE_NONE |=> !$rose(irq_flag_r))
        else $error("flag without repeat area");
    a_rie_off: assert property (xfer_ev && !ctrl_r[RIE_BIT] && !(wr_hit && avs_address == OFF_MODE)
        |=> xfer_active_r && !$rose(irq_flag_r))
        else $error("disabled overflow stopped the channel");
    a_wrap_start: assert property (overflow_now && upd_mode == UPD_INC
        |=> (dest_addr & $past(area_mask)) == '0
            && ((dest_addr ^ $past(dest_addr)) & ~$past(area_mask)) == '0)
        else $error("increment wrap not to area start");

    // decrement overflow must land on the last byte of the area
    sequence s_dec_overflow;
        overflow_now && upd_mode == UPD_DEC;
    endsequence

    // a request seen on an idle edge; the slave owes the answer on the next one
    sequence s_bus_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    // wrap targets and area sizing
    a_wrap_last: assert property (s_dec_overflow
        |=> (dest_addr & $past(area_mask)) == $past(area_mask)
            && ((dest_addr ^ $past(dest_addr)) & ~$past(area_mask)) == '0)
        else $error("decrement wrap not to area end");
    a_area_none: assert property (ctrl_r[AREA_MSB:0] == CODE_NONE |-> area_mask == '0)
        else $error("repeat area without a code");
    a_area_size: assert property (ctrl_r[AREA_MSB:0] != CODE_NONE && ctrl_r[AREA_MSB:0] <= CODE_MAX
        |-> $onehot({1'b0, area_mask} + 25'h0000001) && !area_mask[ctrl_r[AREA_MSB:0]]
            && area_mask[ctrl_r[AREA_MSB:0] - 5'h01])
        else $error("repeat area size not two to the code");

    // control bits come out of reset cleared
    a_reset_ctrl: assert property ($rose(nrst) |-> ctrl_r[UPD_HI_BIT:RIE_BIT] == 3'b000)
        else $error("control bits not clear after reset");

    // flag and interrupt line: only an enabled flag may pull the line
    a_irq_quiet: assert property (!(irq_flag_r && channel_irq_en_r) |=> !irq)
        else $error("interrupt without an enabled flag");
    a_flag_sticky: assert property (irq_flag_r && !(wr_hit && avs_address == OFF_STAT)
        |=> irq_flag_r)
        else $error("flag dropped without a clear");

    // register bus handshake: one wait cycle, never more, never stuck low
    a_bus_answer: assert property (s_bus_take |=> !avs_waitrequest)
        else $error("register access not answered in one cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule // ddauc_top
`default_nettype wire

// *** ddauc_xfer_model.sv ***
// Purpose : transfer engine stand-in that pulses completed transfers into the block
// Assumes : one clock, stimulus changes right after the rising edge
// Notes   : stops issuing once the channel drops xfer_active, like a real engine
`timescale 1ns/10ps
`default_nettype none
module ddauc_xfer_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic [7:0] count,
    input  wire logic       word,
    input  wire logic [3:0] blk_len,
    input  wire logic       xfer_active,
    output logic            xfer_done,
    output logic            xfer_word,
    output logic            block_end,
    output logic            busy
);
    logic [7:0] left_r;
    logic [3:0] pos_r;
    // --------------------------------------------------------------
    // transfer issue
    // --------------------------------------------------------------
    // a halted channel cancels the rest; software restarts it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left_r    <= 8'h00;
            pos_r     <= 4'h0;
            xfer_done <= 1'b0;
            xfer_word <= 1'b0;
            block_end <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            block_end <= 1'b0;
            xfer_word <= ~xfer_word; // qualifier is junk between pulses
            if (start) begin
                left_r <= count;
                pos_r  <= 4'h0;
            end else if (!xfer_active) begin
                left_r <= 8'h00;
            end else if (left_r != 8'h00) begin
                xfer_done <= 1'b1;
                xfer_word <= word;
                block_end <= (pos_r == blk_len - 4'h1); // last of a block
                pos_r     <= (pos_r == blk_len - 4'h1) ? 4'h0 : pos_r + 4'h1;
                left_r    <= left_r - 8'h01;
            end
        end
    end
    assign busy = (left_r != 8'h00) || xfer_done;
endmodule // ddauc_xfer_model
`default_nettype wire

// *** testbench.sv ***
// Purpose : self-checking bench for the destination address update control
// Assumes : one-cycle waitrequest answer, full-word register writes
// Notes   : expectations come from mode codes and area sizes, never from outputs
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ddauc_pkg::*;
    logic              clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
    logic              xfer_done, xfer_word, block_end, xfer_active, start, word, busy;
    logic [BUS_AW-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
    logic [ADDR_W-1:0] dest_addr;
    logic [7:0]        count;
    logic [3:0]        blk_len;
    int                bad_count, tests_run;
    ddauc_top dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .xfer_done(xfer_done), .xfer_word(xfer_word),
        .block_end(block_end), .dest_addr(dest_addr), .xfer_active(xfer_active), .irq(irq));
    ddauc_xfer_model engine (.clk(clk), .nrst(nrst), .start(start), .count(count), .word(word),
        .blk_len(blk_len), .xfer_active(xfer_active), .xfer_done(xfer_done), .xfer_word(xfer_word),
        .block_end(block_end), .busy(busy));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one bus access held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (n >= 20) chk("waitrequest", 32'h1, 32'h0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    // run n transfers from the engine and let irq settle
    task automatic run(input logic [7:0] n, input logic w, input logic [3:0] bl);
        int k;
        @(posedge clk);
        count   <= n;
        word    <= w;
        blk_len <= bl;
        start   <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (busy && k < 100);
        if (k >= 100) chk("engine idle", 32'h1, 32'h0);
        repeat (3) @(posedge clk);
    endtask
    // channel setup: ctrl mode/enable/area, address, flag clear, mode reg
    task automatic setup(input logic [1:0] m, input logic ie, input logic [4:0] ac,
                         input logic [23:0] a, input logic [2:0] md);
        bus(1'b1, OFF_CTRL, {24'h000000, m, ie, ac});
        bus(1'b1, OFF_DADDR, {8'h00, a});
        bus(1'b1, OFF_STAT, 32'h00000001);
        bus(1'b1, OFF_MODE, {29'h00000000, md});
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        logic [BUS_AW-1:0] offs [6] = '{OFF_CTRL, OFF_DADDR, OFF_MODE, OFF_STAT, OFF_MASK, 5'h14};
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 32'h00000000);
            chk("reset read", rd, 32'h00000000);
        end
        bus(1'b1, OFF_CTRL, 32'h000000E0);
        bus(1'b0, OFF_CTRL, 32'h00000000);
        chk("ctrl bits", rd, 32'h000000E0);
        $display("test reset done");
    endtask
    task automatic t_modes();
        logic [23:0] e;
        for (int i = 0; i < 8; i++) begin
            setup(i[2:1], 1'b0, 5'h00, 24'h000100, 3'h1);
            run(8'h01, i[0], 4'h1);
            e = (i[2] == 1'b0) ? 24'h000100 : (i[1] == 1'b0) ? 24'h000100 + (i[0] ? 24'h2 : 24'h1)
                : 24'h000100 - (i[0] ? 24'h2 : 24'h1);
            chk("mode step", {8'h00, dest_addr}, {8'h00, e});
        end
        setup(UPD_INC, 1'b0, 5'h00, 24'h000100, 3'h5);
        run(8'h02, 1'b1, 4'h1);
        chk("ack dest addr", {8'h00, dest_addr}, 32'h00000100);
        $display("test modes done");
    endtask
    task automatic t_wrap_irq();
        bus(1'b1, OFF_MASK, 32'h00000001);
        setup(UPD_INC, 1'b1, 5'h02, 24'h123403, 3'h1);
        run(8'h03, 1'b0, 4'h1);
        chk("inc wrap", {8'h00, dest_addr}, 32'h00123400);
        chk("stopped", {31'h0, xfer_active}, 32'h0);
        chk("irq raised", {31'h0, irq}, 32'h1);
        bus(1'b0, OFF_STAT, 32'h00000000);
        chk("flag", rd, 32'h00000001);
        bus(1'b1, OFF_MASK, 32'h00000000);
        repeat (2) @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        // restart while the flag still stands, so the resume path is exercised
        bus(1'b1, OFF_MODE, 32'h00000001);
        bus(1'b1, OFF_STAT, 32'h00000001);
        bus(1'b0, OFF_STAT, 32'h00000000);
        chk("flag cleared", rd, 32'h00000000);
        chk("restarted", {31'h0, xfer_active}, 32'h1);
        run(8'h01, 1'b1, 4'h1);
        chk("resumed", {8'h00, dest_addr}, 32'h00123402);
        $display("test wrap irq done");
    endtask
    task automatic t_no_stop();
        setup(UPD_DEC, 1'b0, 5'h02, 24'h123400, 3'h1);
        run(8'h01, 1'b0, 4'h1);
        chk("dec wrap", {8'h00, dest_addr}, 32'h00123403);
        chk("still active", {31'h0, xfer_active}, 32'h1);
        bus(1'b0, OFF_STAT, 32'h00000000);
        chk("no flag", rd, 32'h00000000);
        setup(UPD_INC, 1'b1, CODE_NONE, 24'hFFFFFF, 3'h1);
        run(8'h01, 1'b0, 4'h1);
        chk("no area", {8'h00, dest_addr}, 32'h00000000);
        chk("no area active", {31'h0, xfer_active}, 32'h1);
        $display("test no stop done");
    endtask
    task automatic t_block();
        setup(UPD_INC, 1'b1, 5'h02, 24'h000002, 3'h3);
        run(8'h02, 1'b0, 4'h4);
        chk("mid block active", {31'h0, xfer_active}, 32'h1);
        chk("mid block addr", {8'h00, dest_addr}, 32'h00000000);
        run(8'h02, 1'b0, 4'h2);
        chk("block end stop", {31'h0, xfer_active}, 32'h0);
        chk("block end addr", {8'h00, dest_addr}, 32'h00000002);
        $display("test block done");
    endtask
    // --------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        nrst = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0; avs_writedata = '0;
        start = 1'b0; count = 8'h00; word = 1'b0; blk_len = 4'h1;
        bad_count = 0; tests_run = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_modes();
        t_wrap_irq();
        t_no_stop();
        t_block();
        finish_test();
    end
    // generous span: the sequence needs a few hundred cycles
    initial begin
        #80000;
        bad_count++;
        finish_test();
    end
endmodule // testbench
`default_nettype wire
